// >>> rtl/ledfg_top.sv
// LED fault reporting, dimming and output gating top level
//
// Behaviour
// [RULE_01] Channel on with low current reports open code.
// [RULE_02] Off channel: no detection, fault bits read zero.
// [RULE_03] Channel on with high voltage reports short code, else zero.
// [RULE_04] Software should switch off a faulted channel.
// [RULE_05] Overheat disables all outputs and sets flag bit 7.
// [RULE_06] Overheat gone: outputs restored, flag cleared.
// [RULE_07] Enable pin low drives outputs, high makes them float.
// [RULE_08] Pin-synchronised blinking needs drive state fully on first.
// [RULE_09] No pin blink when blinking, no pin dim when dimming.
// [RULE_10] Reset release clears all registers, channels deselected.
// [RULE_11] Reset pin held low at least 2.5 us.
// [RULE_12] Ready at most 1.5 ms after reset pin release.
// [RULE_13] Ack general call write address, nack read.
// [RULE_14] Ack first data byte only when it is 06h.
// [RULE_15] No ack for any byte after the first.
// [RULE_16] Stop after good byte resets registers to defaults.
// [RULE_17] Malformed reset sequence leaves registers alone.
// [RULE_18] Master treats any nack as reset abort.
// [RULE_19] Ready at most 1 ms after soft reset.
// [RULE_20] Per-channel 31.25 kHz PWM with 256 duty steps; the code uses 12-cycle steps at 100 MHz, about 32.55 kHz.
// [RULE_21] Group dimming 122 Hz, 256-step duty over all outputs.
// [RULE_22] Group blinking, 8-bit period 15 Hz to 16.8 s, 8-bit duty; the code reaches about 17.07 s at period 255.
// [RULE_23] Fault code 00 none, 01 short, 10 open, never 11.
// [RULE_24] Bit 6 of mode register shows any channel fault.
// [RULE_25] Fault clears when gone and clear bit written with one.
// [RULE_26] Comparator and overheat inputs synchronised before use.
//
// Our own choices: the strobed register port and the placing of the registers.
module ledfg_top #(
  parameter int NCH          = 16,
  parameter int HW_READY_CYC = ledfg_pkg::HW_READY_CYC,
  parameter int SW_READY_CYC = ledfg_pkg::SW_READY_CYC
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  // Register port
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  // Analog indications
  input  wire logic [NCH-1:0]   i_under_current,
  input  wire logic [NCH-1:0]   i_over_voltage,
  input  wire logic             i_overheat,
  // Output enable pin, low active
  input  wire logic             i_out_en_n,
  // Two-wire bus pins
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  // LED channel drive
  output logic      [NCH-1:0]   o_led_sink,
  output logic                  o_led_hiz,
  output logic                  o_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0][1:0] drv;
    logic [NCH-1:0][7:0] duty;
    logic [7:0]          gduty;
    logic [7:0]          gfreq;
    logic                dmb;
    logic [NCH-1:0]      uc_m;
    logic [NCH-1:0]      uc_s;
    logic [NCH-1:0]      ov_m;
    logic [NCH-1:0]      ov_s;
    logic                ot_m;
    logic                ot_s;
    logic                oe_m;
    logic                oe_s;
    logic [NCH-1:0]      f_open;
    logic [NCH-1:0]      f_short;
    logic [3:0]          pwm_pre;
    logic [7:0]          pwm_cnt;
    logic [23:0]         grp_pre;
    logic [7:0]          grp_cnt;
    logic [17:0]         rdy_cnt;
    logic [7:0]          rdata;
    logic [NCH-1:0]      sink;
    logic                hiz;
  } ledfg_st_t;

  ledfg_st_t r_ff;
  ledfg_st_t nxt_r;

  logic               soft_rst;
  logic [NCH-1:0]     chan_on;
  logic [NCH-1:0]     chan_lit;
  logic [NCH-1:0][1:0] code;
  logic               any_fault;
  logic               clr_cmd;
  logic               ind_pwm;
  logic               grp_pwm;
  logic [23:0]        grp_lim;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Open wins so the code 11 never appears
  function automatic logic [1:0] fault_code(input logic op,
                                            input logic sh);
    if (op)
      fault_code = ledfg_pkg::FLT_OPEN;
    else if (sh)
      fault_code = ledfg_pkg::FLT_SHORT;
    else
      fault_code = ledfg_pkg::FLT_NONE;
  endfunction

  // Register index inside a block of n registers at base
  function automatic logic in_block(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int         n);
    in_block = (a >= base) && (32'(a) < 32'(base) + 32'(n));
  endfunction

  // ----------------------------------------------------------------
  // Soft reset decoder
  // ----------------------------------------------------------------
  ledfg_soft_reset_call u_soft_reset_call (
    .i_clk_sys    (i_clk_sys),
    .i_reset_n    (i_reset_n),
    .i_scl        (i_scl),
    .i_sda        (i_sda),
    .o_sda_out    (o_sda_out),
    .o_sda_oe     (o_sda_oe),
    .o_soft_reset (soft_rst)
  );

  // ----------------------------------------------------------------
  // PWM sources
  // ----------------------------------------------------------------
  // [RULE_20] individual 256-step compare
  assign ind_pwm = 1'b1;
  // [RULE_21] group compare shared by all outputs
  // [RULE_22] same compare for blinking
  assign grp_pwm = (r_ff.grp_cnt < r_ff.gduty);
  // [RULE_22] blink step scales with period register
  assign grp_lim = r_ff.dmb ?
    24'((32'(r_ff.gfreq) + 32'h1) * ledfg_pkg::BLK_STEP_CYC - 1) :
    24'(ledfg_pkg::DIM_STEP_CYC - 1);

  assign clr_cmd = i_wr && (i_addr == ledfg_pkg::ADDR_SECOND_MODE_REG) &&
                   i_wdata[ledfg_pkg::SECOND_MODE_REG_CLR];

  // ----------------------------------------------------------------
  // Per-channel drive and fault code
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic ind_on;
      // [RULE_20] duty compare per channel
      assign ind_on = ind_pwm & (r_ff.pwm_cnt < r_ff.duty[gi]);
      // [RULE_02] off channel not tested
      assign chan_on[gi] = (r_ff.drv[gi] != ledfg_pkg::DRV_OFF);
      always_comb begin
        case (r_ff.drv[gi])
          ledfg_pkg::DRV_ON:  chan_lit[gi] = 1'b1;
          ledfg_pkg::DRV_IND: chan_lit[gi] = ind_on;
          // [RULE_21] group signal superimposed
          ledfg_pkg::DRV_GRP: chan_lit[gi] = ind_on & grp_pwm;
          default:            chan_lit[gi] = 1'b0;
        endcase
      end
      // [RULE_23] two-bit code per channel
      assign code[gi] = chan_on[gi] ?
        fault_code(r_ff.f_open[gi], r_ff.f_short[gi]) :
        ledfg_pkg::FLT_NONE;
    end
  endgenerate

  // [RULE_24] aggregate error status
  assign any_fault = |code;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;

    // [RULE_26] two-stage synchronisers
    nxt_r.uc_m = i_under_current;
    nxt_r.uc_s = r_ff.uc_m;
    nxt_r.ov_m = i_over_voltage;
    nxt_r.ov_s = r_ff.ov_m;
    nxt_r.ot_m = i_overheat;
    nxt_r.ot_s = r_ff.ot_m;
    nxt_r.oe_m = i_out_en_n;
    nxt_r.oe_s = r_ff.oe_m;

    // Individual PWM step prescaler
    if (r_ff.pwm_pre == 4'(ledfg_pkg::PWM_STEP_CYC - 1)) begin
      nxt_r.pwm_pre = 4'h0;
      nxt_r.pwm_cnt = r_ff.pwm_cnt + 8'h1;
    end else begin
      nxt_r.pwm_pre = r_ff.pwm_pre + 4'h1;
    end

    // Group dim or blink step prescaler
    if (r_ff.grp_pre >= grp_lim) begin
      nxt_r.grp_pre = 24'h0;
      nxt_r.grp_cnt = r_ff.grp_cnt + 8'h1;
    end else begin
      nxt_r.grp_pre = r_ff.grp_pre + 24'h1;
    end

    // Fault latches
    for (int k = 0; k < NCH; k++) begin
      // [RULE_25] clear only when gone
      if (clr_cmd && !r_ff.uc_s[k])
        nxt_r.f_open[k] = 1'b0;
      if (clr_cmd && !r_ff.ov_s[k])
        nxt_r.f_short[k] = 1'b0;
      // [RULE_01] open when on and low
      if (chan_on[k] && r_ff.uc_s[k])
        nxt_r.f_open[k] = 1'b1;
      // [RULE_03] short when on and high
      if (chan_on[k] && r_ff.ov_s[k])
        nxt_r.f_short[k] = 1'b1;
      // [RULE_02] nothing kept while off
      if (!chan_on[k]) begin
        nxt_r.f_open[k]  = 1'b0;
        nxt_r.f_short[k] = 1'b0;
      end
    end

    // Register writes
    if (i_wr) begin
      if (in_block(i_addr, ledfg_pkg::ADDR_DUTY0, NCH))
        nxt_r.duty[4'(i_addr - ledfg_pkg::ADDR_DUTY0)] = i_wdata;
      if (in_block(i_addr, ledfg_pkg::ADDR_DRV0,
                   ledfg_pkg::NUM_QUAD)) begin
        for (int q = 0; q < 4; q++)
          nxt_r.drv[6'(4 * 32'(2'(i_addr - ledfg_pkg::ADDR_DRV0))
                      + q)] = i_wdata[2*q +: 2];
      end
      if (i_addr == ledfg_pkg::ADDR_GDUTY)
        nxt_r.gduty = i_wdata;
      if (i_addr == ledfg_pkg::ADDR_GFREQ)
        nxt_r.gfreq = i_wdata;
      if (i_addr == ledfg_pkg::ADDR_SECOND_MODE_REG)
        nxt_r.dmb = i_wdata[ledfg_pkg::SECOND_MODE_REG_DMB];
    end

    // Register reads, data in the following cycle
    if (i_rd) begin
      nxt_r.rdata = 8'h00;
      if (in_block(i_addr, ledfg_pkg::ADDR_DUTY0, NCH))
        nxt_r.rdata = r_ff.duty[4'(i_addr - ledfg_pkg::ADDR_DUTY0)];
      if (in_block(i_addr, ledfg_pkg::ADDR_DRV0,
                   ledfg_pkg::NUM_QUAD)) begin
        for (int q = 0; q < 4; q++)
          nxt_r.rdata[2*q +: 2] =
            r_ff.drv[6'(4 * 32'(2'(i_addr - ledfg_pkg::ADDR_DRV0))
                      + q)];
      end
      if (in_block(i_addr, ledfg_pkg::ADDR_FLT0,
                   ledfg_pkg::NUM_QUAD)) begin
        for (int q = 0; q < 4; q++)
          nxt_r.rdata[2*q +: 2] =
            code[6'(4 * 32'(2'(i_addr - ledfg_pkg::ADDR_FLT0))
                     + q)];
      end
      if (i_addr == ledfg_pkg::ADDR_GDUTY)
        nxt_r.rdata = r_ff.gduty;
      if (i_addr == ledfg_pkg::ADDR_GFREQ)
        nxt_r.rdata = r_ff.gfreq;
      if (i_addr == ledfg_pkg::ADDR_SECOND_MODE_REG) begin
        // [RULE_05] flag at bit 7
        // [RULE_06] flag follows the indication
        nxt_r.rdata[ledfg_pkg::SECOND_MODE_REG_OT]  = r_ff.ot_s;
        // [RULE_24] error bit at bit 6
        nxt_r.rdata[ledfg_pkg::SECOND_MODE_REG_ERR] = any_fault;
        nxt_r.rdata[ledfg_pkg::SECOND_MODE_REG_DMB] = r_ff.dmb;
      end
    end

    // Readiness after reset
    if (r_ff.rdy_cnt != 18'h0)
      nxt_r.rdy_cnt = r_ff.rdy_cnt - 18'h1;

    // [RULE_16] soft reset restores defaults
    if (soft_rst) begin
      nxt_r.drv     = '0;
      nxt_r.duty    = '0;
      nxt_r.gduty   = ledfg_pkg::RST_VAL;
      nxt_r.gfreq   = ledfg_pkg::RST_VAL;
      nxt_r.dmb     = 1'b0;
      nxt_r.f_open  = '0;
      nxt_r.f_short = '0;
      // [RULE_19] ready within 1 ms
      nxt_r.rdy_cnt = 18'(SW_READY_CYC);
    end

    // Output gating
    // [RULE_07] enable pin gates all
    // [RULE_05] overheat disables all
    // [RULE_06] settings kept, so restored
    nxt_r.hiz  = r_ff.oe_s | r_ff.ot_s | (r_ff.rdy_cnt != 18'h0);
    nxt_r.sink = nxt_r.hiz ? '0 : chan_lit;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // [RULE_10] all zero, channels deselected
      r_ff         <= '0;
      r_ff.oe_m    <= 1'b1;
      r_ff.oe_s    <= 1'b1;
      r_ff.hiz     <= 1'b1;
      // [RULE_12] ready within 1.5 ms
      r_ff.rdy_cnt <= 18'(HW_READY_CYC);
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata    = r_ff.rdata;
  assign o_led_sink = r_ff.sink;
  assign o_led_hiz  = r_ff.hiz;
  assign o_ready    = (r_ff.rdy_cnt == 18'h0);

endmodule

// >>> inc/ledfg_pkg.sv
// Shared constants of the LED fault and output gating block
package ledfg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int CLK_MHZ      = 100;
  localparam int PWM_HZ       = 31_250;
  localparam int DIM_HZ       = 122;
  localparam int BLINK_HZ     = 15;
  localparam int PWM_STEPS    = 256;
  localparam int HW_READY_US  = 1500;
  localparam int SW_READY_US  = 1000;
  localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int DIM_STEP_CYC = CLK_HZ / (DIM_HZ * PWM_STEPS);
  localparam int BLK_STEP_CYC = CLK_HZ / (BLINK_HZ * PWM_STEPS);
  localparam int HW_READY_CYC = HW_READY_US * CLK_MHZ;
  localparam int SW_READY_CYC = SW_READY_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DUTY0 = 8'h00;
  localparam logic [7:0] ADDR_DRV0  = 8'h10;
  localparam logic [7:0] ADDR_GDUTY = 8'h14;
  localparam logic [7:0] ADDR_GFREQ = 8'h15;
  localparam logic [7:0] ADDR_SECOND_MODE_REG = 8'h16;
  localparam logic [7:0] ADDR_FLT0  = 8'h17;
  localparam int         NUM_QUAD   = 4;
  localparam int         SECOND_MODE_REG_OT   = 7;
  localparam int         SECOND_MODE_REG_ERR  = 6;
  localparam int         SECOND_MODE_REG_DMB  = 5;
  localparam int         SECOND_MODE_REG_CLR  = 4;
  localparam logic [7:0] RST_VAL    = 8'h00;

  // ----------------------------------------------------------------
  // Drive states, fault codes, soft reset call
  // ----------------------------------------------------------------
  localparam logic [1:0] DRV_OFF    = 2'h0;
  localparam logic [1:0] DRV_ON     = 2'h1;
  localparam logic [1:0] DRV_IND    = 2'h2;
  localparam logic [1:0] DRV_GRP    = 2'h3;
  localparam logic [1:0] FLT_NONE   = 2'h0;
  localparam logic [1:0] FLT_SHORT  = 2'h1;
  localparam logic [1:0] FLT_OPEN   = 2'h2;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [7:0] SOFT_RESET_CALL_BYTE = 8'h06;

endpackage

// >>> rtl/ledfg_soft_reset_call.sv
// General call soft reset decoder on the two-wire bus
module ledfg_soft_reset_call (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  // Two-wire bus pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // Reset request
  output logic      o_soft_reset
);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACKA = 6'h04,
    S_DATA = 6'h08,
    S_ACKD = 6'h10,
    S_XTRA = 6'h20
  } ledfg_gc_st_t;

  typedef struct packed {
    ledfg_gc_st_t st;
    logic         scl_m;
    logic         sda_m;
    logic         scl_s;
    logic         sda_s;
    logic         scl_p;
    logic         sda_p;
    logic [7:0]   shift;
    logic [2:0]   cnt;
    logic         hit;
    logic         full;
    logic         armed;
    logic         oe;
    logic         pulse;
  } ledfg_gc_t;

  ledfg_gc_t r_ff;
  ledfg_gc_t nxt_r;
  logic      rise;
  logic      fall;
  logic      start;
  logic      stop;
  logic [7:0] byte_in;

  assign rise    = r_ff.scl_s & ~r_ff.scl_p;
  assign fall    = ~r_ff.scl_s & r_ff.scl_p;
  assign start   = r_ff.scl_s & r_ff.scl_p & r_ff.sda_p & ~r_ff.sda_s;
  assign stop    = r_ff.scl_s & r_ff.scl_p & ~r_ff.sda_p & r_ff.sda_s;
  assign byte_in = {r_ff.shift[6:0], r_ff.sda_s};

  always_comb begin
    nxt_r       = r_ff;
    nxt_r.scl_m = i_scl;
    nxt_r.sda_m = i_sda;
    nxt_r.scl_s = r_ff.scl_m;
    nxt_r.sda_s = r_ff.sda_m;
    nxt_r.scl_p = r_ff.scl_s;
    nxt_r.sda_p = r_ff.sda_s;
    nxt_r.pulse = 1'b0;
    if (rise) begin
      nxt_r.shift = byte_in;
      nxt_r.cnt   = r_ff.cnt + 3'h1;
    end
    if (start) begin
      nxt_r.st    = S_ADDR;
      nxt_r.cnt   = 3'h0;
      nxt_r.full  = 1'b0;
      nxt_r.armed = 1'b0;
      nxt_r.oe    = 1'b0;
    end else if (stop) begin
      // [RULE_16] reset after stop
      // [RULE_17] only a clean sequence
      nxt_r.pulse = (r_ff.st == S_XTRA) & r_ff.armed;
      nxt_r.st    = S_IDLE;
      nxt_r.armed = 1'b0;
      nxt_r.oe    = 1'b0;
    end else begin
      case (r_ff.st)
        S_IDLE: nxt_r.oe = 1'b0;
        S_ADDR: begin
          // [RULE_13] ack write general call
          if (rise && r_ff.cnt == 3'h7) begin
            nxt_r.hit  = (byte_in == ledfg_pkg::GCALL_ADDR);
            nxt_r.full = 1'b1;
          end
          // Clock fall right after start is no byte end
          if (fall && r_ff.full) begin
            nxt_r.st   = r_ff.hit ? S_ACKA : S_IDLE;
            nxt_r.oe   = r_ff.hit;
            nxt_r.full = 1'b0;
          end
        end
        S_ACKA: if (fall) begin
          nxt_r.st  = S_DATA;
          nxt_r.oe  = 1'b0;
          nxt_r.cnt = 3'h0;
        end
        S_DATA: begin
          // [RULE_14] ack only 06h
          if (rise && r_ff.cnt == 3'h7) begin
            nxt_r.hit  = (byte_in == ledfg_pkg::SOFT_RESET_CALL_BYTE);
            nxt_r.full = 1'b1;
          end
          if (fall && r_ff.full) begin
            nxt_r.st   = r_ff.hit ? S_ACKD : S_IDLE;
            nxt_r.oe   = r_ff.hit;
            nxt_r.full = 1'b0;
          end
        end
        S_ACKD: if (fall) begin
          nxt_r.st    = S_XTRA;
          nxt_r.oe    = 1'b0;
          nxt_r.armed = 1'b1;
        end
        // [RULE_15] no ack beyond first
        // Stop's own clock rise must not cancel, a clocked bit does
        S_XTRA: if (fall) nxt_r.armed = 1'b0;
        default: nxt_r.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_ff       <= '0;
      r_ff.st    <= S_IDLE;
      r_ff.scl_m <= 1'b1;
      r_ff.sda_m <= 1'b1;
      r_ff.scl_s <= 1'b1;
      r_ff.sda_s <= 1'b1;
      r_ff.scl_p <= 1'b1;
      r_ff.sda_p <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_sda_out    = 1'b0;
  assign o_sda_oe     = r_ff.oe;
  assign o_soft_reset = r_ff.pulse;

endmodule

// >>> verif/ledfg_top_properties.sv
// Port checker of the LED fault and gating top
module ledfg_top_properties #(
  parameter int HW_READY_CYC = 20,
  parameter int SW_READY_CYC = 20
) (
  // Watched ports
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic       i_rd,
  input wire logic       i_overheat,
  input wire logic       i_out_en_n,
  input wire logic       i_scl,
  input wire logic [7:0] o_rdata,
  input wire logic       o_sda_oe,
  input wire logic       o_led_hiz,
  input wire logic       o_ready
);
  localparam int LIM = (HW_READY_CYC > SW_READY_CYC ?
                        HW_READY_CYC : SW_READY_CYC) + 3;
  logic [19:0] low_cnt_ff;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // Cycles spent not ready
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) low_cnt_ff <= 20'h0;
    else if (o_ready) low_cnt_ff <= 20'h0;
    else low_cnt_ff <= low_cnt_ff + 20'h1;
  end
  pin_hiz_a : assert property (
    i_out_en_n [*5] |-> o_led_hiz) else $error("enable high, driven");
  heat_hiz_a : assert property (
    i_overheat [*5] |-> o_led_hiz) else $error("overheat, driven");
  unready_hiz_a : assert property (
    !o_ready [*2] |-> o_led_hiz) else $error("not ready, driven");
  drive_on_a : assert property (
    (!i_out_en_n && !i_overheat && o_ready) [*5] |-> !o_led_hiz)
    else $error("outputs float while enabled");
  heat_flag_a : assert property (
    (i_overheat [*5] ##0 (i_rd && i_addr == 8'h16)) |=> o_rdata[7])
    else $error("overheat flag clear");
  clear_bit_a : assert property (
    i_rd && i_addr == 8'h16 |=> !o_rdata[4]) else $error("clear bit reads 1");
  code_legal_a : assert property (
    i_rd && i_addr inside {[8'h17:8'h1a]} |=>
    (o_rdata & (o_rdata >> 1) & 8'h55) == 8'h00) else $error("code 11 seen");
  unmapped_rd_a : assert property (
    i_rd && i_addr > 8'h1a |=> o_rdata == 8'h00) else $error("unmapped read");
  ack_scl_a : assert property (
    $changed(o_sda_oe) |-> !i_scl) else $error("ack moved, clock high");
  ready_bound_a : assert property (
    low_cnt_ff <= 20'(LIM)) else $error("ready too late");
endmodule

bind ledfg_top ledfg_top_properties #(
  .HW_READY_CYC(HW_READY_CYC),
  .SW_READY_CYC(SW_READY_CYC)
) i_props (.i_clk_sys, .i_reset_n, .i_addr, .i_rd, .i_overheat,
  .i_out_en_n, .i_scl, .o_rdata, .o_sda_oe, .o_led_hiz, .o_ready);

// >>> verif/ledfg_bus_master.sv
// Two-wire bus master issuing the soft reset call
module ledfg_bus_master (
  // Bus pins
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Data moves well after the clock falls
  task automatic bit_io(input logic b, output logic rx);
    o_sda_low = !b;
    #22.5 o_scl = 1'b1;
    #62.5 rx = i_sda;
    o_scl = 1'b0;
    #40;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic rx;
    for (int k = 7; k >= 0; k--) bit_io(b[k], rx);
    bit_io(1'b1, rx);
    ack = !rx;
  endtask
  task automatic reset_call(input logic [7:0] adr, input logic [7:0] dat,
                            input logic extra, output logic [2:0] acks);
    acks = 3'h0;
    o_sda_low = 1'b1;
    #62.5 o_scl = 1'b0;
    #40 put_byte(adr, acks[0]);
    if (acks[0]) put_byte(dat, acks[1]);
    if (acks[1] && extra) put_byte(8'h06, acks[2]);
    o_sda_low = 1'b1;
    #22.5 o_scl = 1'b1;
    #62.5 o_sda_low = 1'b0;
    #62.5;
  endtask
endmodule

// >>> verif/ledfg_top_bench.sv
// Self-checking bench of the LED fault and gating top
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); \
  end \
end
module ledfg_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HW = 20;
  localparam int STEP = ledfg_pkg::PWM_STEP_CYC;
  localparam int PER = ledfg_pkg::PWM_STEPS * STEP;
  logic        clk, rst_n, wr, rd, heat, oe_n, scl, mst_low, sda;
  logic        o_sda_out, o_sda_oe, o_led_hiz, o_ready;
  logic [7:0]  addr, wdata, o_rdata;
  logic [15:0] under, over, o_led_sink;
  logic [2:0]  acks;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  // Pulled-up data line
  assign sda = (mst_low || (o_sda_oe && !o_sda_out)) ? 1'b0 : 1'b1;
  ledfg_top #(.NCH(16), .HW_READY_CYC(HW), .SW_READY_CYC(HW)) i_ledfg_top (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata), .i_under_current(under),
    .i_over_voltage(over), .i_overheat(heat), .i_out_en_n(oe_n),
    .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .o_led_sink(o_led_sink), .o_led_hiz(o_led_hiz), .o_ready(o_ready));
  ledfg_bus_master i_ledfg_bus_master (
    .o_scl(scl), .o_sda_low(mst_low), .i_sda(sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) `CHK(o_rdata, e)
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (o_ready !== 1'b1 && n < HW + 9) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_boot;
    int n;
    @(negedge clk) `CHK(o_led_hiz, 1'b1)
    wait_ready(n);
    `CHK(n <= HW + 2, 1'b1)
    chk_rd(8'h13, 8'h00);
    chk_rd(8'h16, 8'h00);
    chk_rd(8'h20, 8'h00);
    $display("test boot done");
  endtask
  task automatic t_faults;
    for (int q = 0; q < 4; q++) wr_reg(8'(8'h10 + q), 8'h55);
    @(posedge clk) begin under <= 16'h0042; over <= 16'h0050; end
    chk_rd(8'h17, 8'h00);
    wait_n(6);
    chk_rd(8'h17, 8'h08);
    chk_rd(8'h18, 8'h21);
    chk_rd(8'h16, 8'h40);
    wr_reg(8'h10, 8'h00);
    chk_rd(8'h17, 8'h00);
    wr_reg(8'h10, 8'h55);
    wr_reg(8'h16, 8'h10);
    chk_rd(8'h18, 8'h21);
    @(posedge clk) begin under <= 16'h0; over <= 16'h0; end
    wait_n(6);
    chk_rd(8'h18, 8'h21);
    wr_reg(8'h16, 8'h10);
    chk_rd(8'h18, 8'h00);
    chk_rd(8'h16, 8'h00);
    $display("test faults done");
  endtask
  task automatic t_heat;
    wait_n(6);
    `CHK(o_led_hiz, 1'b0)
    `CHK(o_led_sink, 16'hffff)
    @(posedge clk) heat <= 1'b1;
    wait_n(6);
    `CHK(o_led_hiz, 1'b1)
    chk_rd(8'h16, 8'h80);
    @(posedge clk) heat <= 1'b0;
    wait_n(6);
    `CHK(o_led_hiz, 1'b0)
    `CHK(o_led_sink, 16'hffff)
    chk_rd(8'h16, 8'h00);
    // enable pin high floats outputs with all channels fully on
    @(posedge clk) oe_n <= 1'b1;
    wait_n(6);
    `CHK(o_led_hiz, 1'b1)
    @(posedge clk) oe_n <= 1'b0;
    $display("test heat done");
  endtask
  task automatic count_lit(output int hi);
    hi = 0;
    repeat (PER) begin
      @(negedge clk);
      hi += int'(o_led_sink[0] === 1'b1);
    end
  endtask
  task automatic t_pwm;
    int hi;
    wr_reg(8'h10, 8'h56);
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h00, 8'(k * 8'h55));
      wait_n(PER);
      count_lit(hi);
      `CHK(hi, k * 8'h55 * STEP)
    end
    // Grouped channel with group duty zero stays dark
    wr_reg(8'h14, 8'h00);
    wr_reg(8'h10, 8'h57);
    wait_n(8);
    count_lit(hi);
    `CHK(hi, 0)
    wr_reg(8'h16, 8'h20);
    wait_n(8);
    count_lit(hi);
    `CHK(hi, 0)
    wr_reg(8'h16, 8'h00);
    wr_reg(8'h10, 8'h55);
    $display("test pwm done");
  endtask
  task automatic t_soft_reset_call;
    int n;
    wr_reg(8'h16, 8'h20);
    i_ledfg_bus_master.reset_call(8'h01, 8'h06, 1'b0, acks);
    `CHK(acks, 3'h0)
    i_ledfg_bus_master.reset_call(8'h00, 8'h07, 1'b0, acks);
    `CHK(acks, 3'h1)
    i_ledfg_bus_master.reset_call(8'h00, 8'h06, 1'b1, acks);
    `CHK(acks, 3'h3)
    chk_rd(8'h16, 8'h20);
    chk_rd(8'h13, 8'h55);
    i_ledfg_bus_master.reset_call(8'h00, 8'h06, 1'b0, acks);
    `CHK(acks, 3'h3)
    @(negedge clk) `CHK(o_ready, 1'b0)
    wait_ready(n);
    `CHK(n <= HW, 1'b1)
    chk_rd(8'h16, 8'h00);
    chk_rd(8'h13, 8'h00);
    $display("test soft reset done");
  endtask
  initial begin
    {rst_n, wr, rd, heat, oe_n, addr, wdata, under, over} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_boot;
    t_faults;
    t_heat;
    t_pwm;
    t_soft_reset_call;
    wr_reg(8'h13, 8'h55);
    @(posedge clk) rst_n <= 1'b0;
    repeat (250) @(posedge clk);
    rst_n <= 1'b1;
    t_boot;
    tally_and_finish;
  end
endmodule
